// ==== logic/aff_map.svh ====
// Purpose: register offsets, field positions and reset values of the fault block
// Assumes: 8-bit register address, 16-bit register data
// Notes: definitions only
`ifndef AFF_MAP_SVH
`define AFF_MAP_SVH

`define AFF_ADDR_RAW 8'h2d
`define AFF_ADDR_SUBST 8'h2e
`define AFF_ADDR_INJECT 8'h2f
`define AFF_RESET_WORD 16'h0000
`define AFF_SUB_DATA_EN 15
`define AFF_SUB_OFST_EN 14
`define AFF_SUB_GND_DIS 13
`define AFF_SUB_DATA_HI 11
`define AFF_RAW_PAD 4'h0
`define AFF_CODE_MAX 13'h0fff
`define AFF_CODE_MIN 13'h0000
`define AFF_NUM_DIAG 3'h5
`define AFF_CRC_RESET 8'h00

`endif

// ==== logic/aff_pkg.sv ====
// Purpose: shared types of the adc bypass and fault injection block
// Assumes: five diagnostic channels, 12-bit conversions
// Notes: inject struct follows the register bit layout msb first
package aff_pkg;

    typedef logic [4:0][11:0] aff_chan_t;

    typedef struct packed {
        logic result_substitute_enable;
        logic offset_substitute_enable;
        logic ground_discharge_disable;
        logic [11:0] bypass_data;
    } aff_subst_s;

    typedef struct packed {
        logic checksum_fault_inject;
        logic reference_fault_inject;
        logic overtemp_error_inject;
        logic overtemp_warning_inject;
        logic [1:0] spare;
        logic output_node_high_inject;
        logic output_node_low_inject;
        logic zero_tc_node_high_inject;
        logic zero_tc_node_low_inject;
        logic core_supply_high_inject;
        logic core_supply_low_inject;
        logic main_supply_high_inject;
        logic main_supply_low_inject;
        logic reference_level_high_inject;
        logic reference_level_low_inject;
    } aff_inject_s;

    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic [11:0] data;
    } aff_conv_s;

    typedef struct packed {
        logic ref_fail;
        logic overtemp_error;
        logic overtemp_warning;
    } aff_analog_s;

    typedef struct packed {
        logic ref_fail;
        logic overtemp_error;
        logic overtemp_warning;
        logic [4:0] high_fail;
        logic [4:0] low_fail;
    } aff_fault_s;

    typedef struct packed {
        aff_subst_s subst;
        aff_inject_s inject;
        logic [11:0] raw;
        aff_conv_s result;
        aff_chan_t readback;
        logic [4:0] meas_high;
        logic [4:0] meas_low;
        aff_fault_s fault;
        logic [7:0] crc;
        logic [15:0] rdata;
        logic rvalid;
    } aff_state_s;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] level;
    } aff_sync_s;

endpackage : aff_pkg

// ==== logic/aff_pin_sync.sv ====
// Purpose: brings the analog monitor levels into the clock domain
// Assumes: inputs are slow levels from the analog monitors
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
`include "aff_map.svh"

module aff_pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // levels
    input wire aff_pkg::aff_analog_s async_in,
    output aff_pkg::aff_analog_s sync_out
);
    import aff_pkg::*;

    aff_sync_s st;
    aff_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // stage one is never looked at here, only stage two and three
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.level;

endmodule : aff_pin_sync

// ==== logic/aff_result_select.sv ====
// Purpose: picks the corrected conversion result from raw, offset and bypass
// Assumes: offset values are 12-bit two's complement
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ps
`include "aff_map.svh"

module aff_result_select (
    // inputs
    input wire logic [11:0] raw,
    input wire logic [11:0] offset_value,
    input wire aff_pkg::aff_subst_s subst,
    // result
    output logic [11:0] result
);
    import aff_pkg::*;

    // saturate rather than wrap: a wrapped code would fake a limit fault
    function automatic logic [11:0] aff_add_offset(input logic [11:0] code,
                                                   input logic [11:0] ofs);
        logic signed [13:0] sum;
        sum = $signed({2'b00, code}) + $signed({{2{ofs[11]}}, ofs});
        if (sum < $signed({1'b0, `AFF_CODE_MIN})) begin
            aff_add_offset = 12'(`AFF_CODE_MIN);
        end else if (sum > $signed({1'b0, `AFF_CODE_MAX})) begin
            aff_add_offset = 12'(`AFF_CODE_MAX);
        end else begin
            aff_add_offset = sum[11:0];
        end
    endfunction : aff_add_offset

    always_comb begin
        if (subst.result_substitute_enable) begin
            result = subst.bypass_data; // RULE3 RULE4
        end else if (subst.offset_substitute_enable) begin
            result = aff_add_offset(raw, subst.bypass_data); // RULE7 RULE8
        end else begin
            result = aff_add_offset(raw, offset_value);
        end
    end

endmodule : aff_result_select

// ==== logic/aff_fault_ctrl.sv ====
// Purpose: adc bypass, raw result capture and safety fault injection
// Assumes: register port from the serial framer, one conversion strobe per result
// Notes: all outputs come from flops; fault outputs are levels
`timescale 1ns/1ps
`include "aff_map.svh"

//
// Overview of operation
// [RULE1] raw 12-bit result lands in low field of raw register, no offset, top zero
// [RULE2] raw register always shows converter output, never bypass data
// [RULE3] data substitute enable uses bypass value as result, offset ignored
// [RULE4] both substitute enables set: only data substitution applies
// [RULE5] substituted value goes to channel readback and is checked against limits
// [RULE6] host sets at most one of the two substitute enables
// [RULE7] offset substitute enable uses bypass value instead of offset register
// [RULE8] bypass value taken as signed twos complement for offset substitution
// [RULE9] ground sampling between conversions unless disable bit is set
// [RULE10] checksum inject inverts every bit of the outgoing crc byte
// [RULE11] reference inject raises reference failure like the monitor would
// [RULE12] overtemp error inject raises the over-temperature error
// [RULE13] overtemp warning inject raises the temperature warning
// [RULE14] two bits force high and low failure on output node channel
// [RULE15] two bits force high and low failure on zero-tc node channel
// [RULE16] two bits force high and low failure on core supply channel
// [RULE17] two bits force high and low failure on main supply channel
// [RULE18] two bits force high and low failure on reference channel
// [RULE19] reset clears all inject bits, substitute enables and ground disable
// [RULE20] forced faults feed normal fault outputs and hold while bit is set
module aff_fault_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // conversion from the sequencer
    input wire aff_pkg::aff_conv_s conv_in,
    input wire logic [11:0] offset_value,
    output logic gnd_sample_enable,
    output aff_pkg::aff_conv_s result_out,
    output aff_pkg::aff_chan_t readback,
    // limits per diagnostic channel
    input wire aff_pkg::aff_chan_t limit_high,
    input wire aff_pkg::aff_chan_t limit_low,
    // analog monitors and fault outputs
    input wire aff_pkg::aff_analog_s monitor_in,
    output aff_pkg::aff_fault_s fault_out,
    // checksum byte towards the serial output
    input wire logic [7:0] crc_in,
    output logic [7:0] crc_out
);
    import aff_pkg::*;

    aff_state_s st;
    aff_state_s next_st;
    aff_analog_s monitor_sync;
    logic [11:0] corrected;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // channel index 4 is the output node, 0 the reference
    function automatic logic [4:0] aff_inj_high(input aff_inject_s inj);
        aff_inj_high = {inj.output_node_high_inject, inj.zero_tc_node_high_inject,
                        inj.core_supply_high_inject, inj.main_supply_high_inject,
                        inj.reference_level_high_inject};
    endfunction : aff_inj_high

    function automatic logic [4:0] aff_inj_low(input aff_inject_s inj);
        aff_inj_low = {inj.output_node_low_inject, inj.zero_tc_node_low_inject,
                       inj.core_supply_low_inject, inj.main_supply_low_inject,
                       inj.reference_level_low_inject};
    endfunction : aff_inj_low

    function automatic logic aff_is_diag(input logic [2:0] ch);
        aff_is_diag = (ch < `AFF_NUM_DIAG);
    endfunction : aff_is_diag

    ////////////////////////////////////////////////////////////////////////////
    // sub blocks

    aff_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(monitor_in),
        .sync_out(monitor_sync)
    );

    aff_result_select u_select (
        .raw(conv_in.data),
        .offset_value(offset_value),
        .subst(st.subst),
        .result(corrected)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.result.valid = 1'b0;

        // register writes; raw register is read only
        if (reg_wr) begin
            unique case (reg_addr)
                `AFF_ADDR_SUBST: begin
                    next_st.subst.result_substitute_enable = reg_wdata[`AFF_SUB_DATA_EN];
                    next_st.subst.offset_substitute_enable = reg_wdata[`AFF_SUB_OFST_EN];
                    next_st.subst.ground_discharge_disable = reg_wdata[`AFF_SUB_GND_DIS];
                    next_st.subst.bypass_data = reg_wdata[`AFF_SUB_DATA_HI:0];
                end
                `AFF_ADDR_INJECT: begin
                    next_st.inject = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // reads answer one cycle later; unmapped reads as zero
        if (reg_rd) begin
            next_st.rvalid = 1'b1;
            unique case (reg_addr)
                `AFF_ADDR_RAW: begin
                    next_st.rdata = {`AFF_RAW_PAD, st.raw}; // RULE1
                end
                `AFF_ADDR_SUBST: begin
                    next_st.rdata = {st.subst.result_substitute_enable,
                                     st.subst.offset_substitute_enable,
                                     st.subst.ground_discharge_disable,
                                     1'b0, st.subst.bypass_data};
                end
                `AFF_ADDR_INJECT: begin
                    next_st.rdata = st.inject;
                end
                default: begin
                    next_st.rdata = `AFF_RESET_WORD;
                end
            endcase
        end

        // conversion: raw keeps the converter value, result may be substituted
        if (conv_in.valid) begin
            next_st.raw = conv_in.data; // RULE1 RULE2
            next_st.result.valid = 1'b1;
            next_st.result.channel = conv_in.channel;
            next_st.result.data = corrected; // RULE3 RULE4 RULE7
            if (aff_is_diag(conv_in.channel)) begin
                next_st.readback[conv_in.channel] = corrected; // RULE5
                next_st.meas_high[conv_in.channel] =
                    corrected > limit_high[conv_in.channel]; // RULE5
                next_st.meas_low[conv_in.channel] =
                    corrected < limit_low[conv_in.channel]; // RULE5
            end
        end

        // forced faults merge with measured ones and hold while set
        next_st.fault.ref_fail =
            monitor_sync.ref_fail | st.inject.reference_fault_inject; // RULE11 RULE20
        next_st.fault.overtemp_error =
            monitor_sync.overtemp_error | st.inject.overtemp_error_inject; // RULE12
        next_st.fault.overtemp_warning =
            monitor_sync.overtemp_warning | st.inject.overtemp_warning_inject; // RULE13
        // RULE14 RULE15 RULE16 RULE17 RULE18
        next_st.fault.high_fail = next_st.meas_high | aff_inj_high(st.inject);
        next_st.fault.low_fail = next_st.meas_low | aff_inj_low(st.inject);

        // inverting the whole byte guarantees the host sees a mismatch
        next_st.crc = st.inject.checksum_fault_inject ? ~crc_in : crc_in; // RULE10
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0; // RULE19
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign result_out = st.result;
    assign readback = st.readback;
    assign fault_out = st.fault;
    assign crc_out = st.crc;
    // ground sampling runs by default so crosstalk stays low
    assign gnd_sample_enable = ~st.subst.ground_discharge_disable; // RULE9

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking aff_cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_raw_capture: assert property ( // RULE1 RULE2
        conv_in.valid |=> st.raw == $past(conv_in.data)
    ) else $error("raw register does not hold the converter value");

    a_raw_upper_zero: assert property ( // RULE1
        reg_rd && reg_addr == `AFF_ADDR_RAW |=> reg_rvalid && reg_rdata[15:12] == 4'h0
                                               && reg_rdata[11:0] == $past(st.raw)
    ) else $error("raw register read is wrong");

    a_data_substitute: assert property ( // RULE3 RULE4
        conv_in.valid && st.subst.result_substitute_enable
        |=> result_out.valid && result_out.data == $past(st.subst.bypass_data)
    ) else $error("data substitution not applied");

    a_readback_write: assert property ( // RULE5
        conv_in.valid && aff_is_diag(conv_in.channel)
        |=> readback[$past(conv_in.channel)] == result_out.data
    ) else $error("readback not written with result");

    a_offset_signed: assert property ( // RULE7 RULE8
        conv_in.valid && !st.subst.result_substitute_enable
        && st.subst.offset_substitute_enable && st.subst.bypass_data[11]
        |=> result_out.data <= $past(conv_in.data)
    ) else $error("negative offset bypass raised the code");

    a_ground_disable: assert property ( // RULE9
        reg_wr && reg_addr == `AFF_ADDR_SUBST
        |=> gnd_sample_enable == !$past(reg_wdata[`AFF_SUB_GND_DIS])
    ) else $error("ground sampling not suppressed");

    a_crc_invert: assert property ( // RULE10
        st.inject.checksum_fault_inject |=> crc_out == ~$past(crc_in)
    ) else $error("crc byte not inverted");

    a_ref_forced: assert property ( // RULE11 RULE20
        st.inject.reference_fault_inject [*2] |-> fault_out.ref_fail
    ) else $error("forced reference fault missing");

    a_therm_forced: assert property ( // RULE12
        st.inject.overtemp_error_inject |=> fault_out.overtemp_error
    ) else $error("forced thermal error missing");

    a_warn_forced: assert property ( // RULE13
        st.inject.overtemp_warning_inject |=> fault_out.overtemp_warning
    ) else $error("forced thermal warning missing");

    a_chan_high_force: assert property ( // RULE14 RULE15 RULE16 RULE17 RULE18
        1'b1 |=> (fault_out.high_fail & aff_inj_high($past(st.inject)))
                 == aff_inj_high($past(st.inject))
    ) else $error("forced high limit fault missing");

    a_chan_low_force: assert property ( // RULE14 RULE15 RULE16 RULE17 RULE18
        1'b1 |=> (fault_out.low_fail & aff_inj_low($past(st.inject)))
                 == aff_inj_low($past(st.inject))
    ) else $error("forced low limit fault missing");

    // limit flags judge the stored value, bypass included

    a_high_measured: assert property ( // RULE5
        conv_in.valid && aff_is_diag(conv_in.channel)
        && corrected > limit_high[conv_in.channel]
        |=> fault_out.high_fail[$past(conv_in.channel)]
    ) else $error("measured high limit fault missing");

    a_low_measured: assert property ( // RULE5
        conv_in.valid && aff_is_diag(conv_in.channel)
        && corrected < limit_low[conv_in.channel]
        |=> fault_out.low_fail[$past(conv_in.channel)]
    ) else $error("measured low limit fault missing");

    a_data_readback: assert property ( // RULE5
        conv_in.valid && aff_is_diag(conv_in.channel)
        && st.subst.result_substitute_enable
        |=> readback[$past(conv_in.channel)] == $past(st.subst.bypass_data)
    ) else $error("readback does not hold bypass data");

    a_nondiag_keep: assert property ( // RULE5
        conv_in.valid && !aff_is_diag(conv_in.channel)
        |=> $stable(readback)
    ) else $error("non-diagnostic channel touched readback");

    a_result_channel: assert property ( // RULE5
        conv_in.valid
        |=> result_out.channel == $past(conv_in.channel)
    ) else $error("result channel mismatch");

    a_both_enables: assert property ( // RULE4
        conv_in.valid && st.subst.result_substitute_enable
        && st.subst.offset_substitute_enable
        |=> result_out.data == $past(st.subst.bypass_data)
    ) else $error("offset substitution won over data substitution");

    a_raw_write_ignored: assert property ( // RULE1
        reg_wr && reg_addr == `AFF_ADDR_RAW && !conv_in.valid
        |=> $stable(st.raw)
    ) else $error("write changed the raw register");

    a_crc_pass: assert property ( // RULE10
        !st.inject.checksum_fault_inject
        |=> crc_out == $past(crc_in)
    ) else $error("crc byte altered without injection");

    a_ref_monitor: assert property ( // RULE11
        monitor_sync.ref_fail
        |=> fault_out.ref_fail
    ) else $error("monitored reference fault missing");

    // a released fault must drop unless the monitor still reports it

    a_ref_release: assert property ( // RULE20
        !st.inject.reference_fault_inject && !monitor_sync.ref_fail
        |=> !fault_out.ref_fail
    ) else $error("reference fault stuck");

    a_error_release: assert property ( // RULE20
        !st.inject.overtemp_error_inject && !monitor_sync.overtemp_error
        |=> !fault_out.overtemp_error
    ) else $error("thermal error stuck");

    a_warning_release: assert property ( // RULE20
        !st.inject.overtemp_warning_inject && !monitor_sync.overtemp_warning
        |=> !fault_out.overtemp_warning
    ) else $error("thermal warning stuck");

    a_reset_clear: assert property (@(posedge clk) // RULE19
        $fell(srst) |-> st.inject == '0 && st.subst == '0 && gnd_sample_enable
    ) else $error("reset did not clear control bits");

    c_data_subst: cover property (conv_in.valid && st.subst.result_substitute_enable);
    c_ofst_subst: cover property (conv_in.valid && st.subst.offset_substitute_enable);
    c_crc_inject: cover property (st.inject.checksum_fault_inject ##1 crc_out != crc_in);
    c_high_force: cover property (fault_out.high_fail[4] && !st.meas_high[4]);
    c_ref_monitor: cover property (monitor_sync.ref_fail ##1 fault_out.ref_fail);

endmodule : aff_fault_ctrl

// ==== bench/aff_host_model.sv ====
// Purpose: host side of the register port, issuing single reads and writes
// Assumes: strobes change just after a rising edge, one request at a time
// Notes: idle address shows the inverse of the last request, idle data the inverse of the last write
`timescale 1ns/1ps

module aff_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask : wr

    // answer stands in the cycle after the edge that takes the read
    task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        ok = reg_rvalid;
        data = reg_rdata;
    endtask : rd
endmodule : aff_host_model

// ==== bench/aff_fault_ctrl_tb.sv ====
// Purpose: self-checking bench of the adc bypass and fault injection block
// Assumes: host model owns the register port, bench drives the sequencer side
// Notes: limits fixed at 0x010..0xa00 on every channel
`timescale 1ns/1ps
`include "aff_map.svh"

module aff_fault_ctrl_tb;
    import aff_pkg::*;

    logic clk;
    logic srst;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, crc_in, crc_out;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] offset_value;
    logic gnd_sample_enable;
    aff_conv_s conv_in, result_out;
    aff_chan_t readback, limit_high, limit_low;
    aff_analog_s monitor_in;
    aff_fault_s fault_out;
    int n_mismatch = 0;
    int total_checks = 0;

    aff_host_model i_aff_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    aff_fault_ctrl i_aff_fault_ctrl (.clk(clk), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_in(conv_in),
        .offset_value(offset_value), .gnd_sample_enable(gnd_sample_enable),
        .result_out(result_out), .readback(readback), .limit_high(limit_high),
        .limit_low(limit_low), .monitor_in(monitor_in), .fault_out(fault_out),
        .crc_in(crc_in), .crc_out(crc_out));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_fault(input aff_fault_s exp);
        total_checks++;
        if (fault_out !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t fault got %h exp %h", $time, fault_out, exp);
        end
    endtask : chk_fault

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        i_aff_host_model.rd(a, d, ok);
        chk_word({15'h0, ok}, 16'h0001, "read answer");
        chk_word(d, e, "read data");
    endtask : rchk

    // one conversion, result checked just after the edge that takes it
    task automatic conv(input logic [2:0] ch, input logic [11:0] d, input logic [11:0] e);
        @(posedge clk);
        conv_in <= {1'b1, ch, d};
        @(posedge clk);
        conv_in <= '0;
        #1;
        chk_word({15'h0, result_out.valid}, 16'h0001, "result valid");
        chk_word({4'h0, result_out.data}, {4'h0, e}, "result data");
        chk_word({13'h0, result_out.channel}, {13'h0, ch}, "result channel");
    endtask : conv

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        chk_word({15'h0, gnd_sample_enable}, 16'h0001, "gnd after reset");
        chk_fault('0);
        rchk(`AFF_ADDR_SUBST, `AFF_RESET_WORD);
        rchk(`AFF_ADDR_INJECT, `AFF_RESET_WORD);
        i_aff_host_model.wr(`AFF_ADDR_RAW, 16'hffff);
        rchk(`AFF_ADDR_RAW, `AFF_RESET_WORD);
        rchk(8'h40, 16'h0000);
    endtask : t_reset

    task automatic t_raw();
        conv(3'h2, 12'h123, 12'h120);
        rchk(`AFF_ADDR_RAW, 16'h0123);
        conv(3'h6, 12'h200, 12'h1fd);
        chk_word({4'h0, readback[2]}, 16'h0120, "readback kept");
        rchk(`AFF_ADDR_RAW, 16'h0200);
    endtask : t_raw

    task automatic t_data_sub();
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'h8abc);
        conv(3'h4, 12'h100, 12'habc);
        chk_word({4'h0, readback[4]}, 16'h0abc, "readback");
        chk_fault(13'h0200);
        rchk(`AFF_ADDR_RAW, 16'h0100);
    endtask : t_data_sub

    task automatic t_both();
        // host breaks the exclusive-enable habit on purpose here
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'hc7ff);
        conv(3'h4, 12'h200, 12'h7ff);
        chk_fault('0);
    endtask : t_both

    task automatic t_ofst_sub();
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'h4ffe);
        conv(3'h1, 12'h050, 12'h04e);
        conv(3'h1, 12'h001, 12'h000);
        chk_fault(13'h0002);
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'h0000);
        conv(3'h1, 12'h100, 12'h0fd);
        chk_fault('0);
    endtask : t_ofst_sub

    task automatic t_gnd();
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'h3000);
        @(posedge clk);
        #1;
        chk_word({15'h0, gnd_sample_enable}, 16'h0000, "gnd disabled");
        rchk(`AFF_ADDR_SUBST, 16'h2000);
        i_aff_host_model.wr(`AFF_ADDR_SUBST, 16'h0000);
        @(posedge clk);
        #1;
        chk_word({15'h0, gnd_sample_enable}, 16'h0001, "gnd enabled");
    endtask : t_gnd

    // each inject bit alone; the previous one must have dropped
    task automatic t_inject();
        aff_fault_s ex;
        for (int i = 0; i < 16; i++) begin
            ex = '0;
            if (i < 10 && i % 2 == 1) ex.high_fail[i / 2] = 1'b1;
            if (i < 10 && i % 2 == 0) ex.low_fail[i / 2] = 1'b1;
            ex.overtemp_warning = (i == 12);
            ex.overtemp_error = (i == 13);
            ex.ref_fail = (i == 14);
            i_aff_host_model.wr(`AFF_ADDR_INJECT, 16'h0001 << i);
            @(posedge clk);
            #1;
            chk_fault(ex);
            chk_word({8'h0, crc_out}, {8'h0, (i == 15) ? ~crc_in : crc_in}, "crc");
            rchk(`AFF_ADDR_INJECT, 16'h0001 << i);
            chk_fault(ex);
        end
        i_aff_host_model.wr(`AFF_ADDR_INJECT, 16'h0000);
        @(posedge clk);
        #1;
        chk_fault('0);
    endtask : t_inject

    task automatic t_monitor();
        @(posedge clk);
        monitor_in <= 3'b100;
        for (int k = 0; k < 8 && fault_out.ref_fail !== 1'b1; k++) @(posedge clk);
        #1;
        chk_fault(13'h1000);
        @(posedge clk);
        monitor_in <= 3'b000;
        repeat (8) @(posedge clk);
        #1;
        chk_fault('0);
    endtask : t_monitor

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        conv_in = '0;
        offset_value = 12'hffd;
        limit_high = {5{12'ha00}};
        limit_low = {5{12'h010}};
        monitor_in = '0;
        crc_in = 8'h5a;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_raw();
        t_data_sub();
        t_both();
        t_ofst_sub();
        t_gnd();
        t_inject();
        t_monitor();
        test_done();
    end

    // whole run is under 200 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule : aff_fault_ctrl_tb
